// *** verilog/socfl_pkg.sv ***
// Purpose: constants and types of the charge warning and load model block
// Assumes: one measurement sample per second, byte addresses on AHB-Lite
// Notes:   signed 16-bit values except the unsigned voltage, capacities in mAh
//
// Notes on behaviour
// RQ1: Integrate cell current into remaining capacity.
// RQ2: Full capacity bounds the remaining capacity value.
// RQ3: Below first set threshold, raise initial flag.
// RQ4: Initial flag clears only above its clear threshold.
// RQ5: Below final set threshold, raise final flag.
// RQ6: Final set threshold of minus one disables.
// RQ7: Set final flag clears above its clear threshold.
// RQ8: Load model zero current, one power; default zero.
// RQ9: Load model mirrored in control status bit.
// RQ10: Current model selects seven sources, default one.
// RQ11: Power model selects seven sources, default zero; the shared selector resets to one.
// RQ12: Keep previous discharge cycle average as option zero.
// RQ13: Option three is 14 s filtered mean current.
// RQ14: Current option four is design capacity over five.
// RQ15: Power option four is design energy over five.
// RQ16: Power option two is mean current times voltage.
// RQ17: Power option five reads rate in 10 mW.
// RQ18: Both flags re-evaluated at every capacity update. The code re-evaluates them only at a sample, not on a write of rc.
package socfl_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00; // Load model and selector
	localparam logic [7:0] A_FLAGS = 8'h04; // Warning flag word
	localparam logic [7:0] A_S1SET = 8'h08; // Initial set threshold
	localparam logic [7:0] A_S1CLR = 8'h0c; // Initial clear threshold
	localparam logic [7:0] A_SFSET = 8'h10; // Final set threshold
	localparam logic [7:0] A_SFCLR = 8'h14; // Final clear threshold
	localparam logic [7:0] A_DCAP  = 8'h18; // Design capacity, mAh
	localparam logic [7:0] A_DEN   = 8'h1c; // Design energy, 10 mWh
	localparam logic [7:0] A_HRATE = 8'h20; // Hypothetical rate
	localparam logic [7:0] A_URATE = 8'h24; // User rate
	localparam logic [7:0] A_RC    = 8'h28; // Remaining capacity
	localparam logic [7:0] A_FCAP  = 8'h2c; // Full capacity
	localparam logic [7:0] A_RATE  = 8'h30; // Chosen load rate
	localparam logic [7:0] A_ISTAT = 8'h34; // Sticky event status
	localparam logic [7:0] A_IEN   = 8'h38; // Interrupt enable
	localparam logic [7:0] A_ICLR  = 8'h3c; // Write one to clear
	localparam logic [7:0] A_CSTAT = 8'h40; // Control status word

	// ==========================================================
	// Field positions
	localparam int unsigned CTRL_MODE_BIT = 0; // Load model bit
	localparam int unsigned CTRL_SEL_LSB  = 4; // Selector, 3 bits
	localparam int unsigned FLAG_FINAL    = 1; // Final flag bit
	localparam int unsigned FLAG_INIT     = 2; // Initial flag bit
	localparam int unsigned CSTAT_LOAD_MODEL_STATUS_BIT    = 0; // Mirror of load model
	localparam int unsigned EV_S1SET      = 0; // Initial flag raised
	localparam int unsigned EV_S1CLR      = 1; // Initial flag dropped
	localparam int unsigned EV_SFSET      = 2; // Final flag raised
	localparam int unsigned EV_SFCLR      = 3; // Final flag dropped
	localparam int unsigned EV_CYC        = 4; // Discharge cycle ended
	localparam int unsigned NEV           = 5; // Number of events

	// ==========================================================
	// Arithmetic constants
	localparam logic signed [17:0] MAS_PER_MAH = 18'sh00e10; // 3600 mAs
	localparam logic signed [32:0] UW_PER_CW   = 33'sh002710; // 10000
	localparam logic signed [16:0] TAU_S       = 17'sh0000e; // 14 s
	localparam logic signed [15:0] C_DIV       = 16'sh0005; // C/5
	localparam logic signed [15:0] SF_OFF      = 16'shffff; // Minus one

	// ==========================================================
	// Reset values
	localparam logic       RST_MODE  = 1'b0;
	localparam logic [2:0] RST_SEL   = 3'h1;
	localparam logic signed [15:0] RST_S1SET = 16'sh0096;
	localparam logic signed [15:0] RST_S1CLR = 16'sh00af;
	localparam logic signed [15:0] RST_SFSET = 16'sh004b;
	localparam logic signed [15:0] RST_SFCLR = 16'sh0064;
	localparam logic signed [15:0] RST_DCAP  = 16'sh03e8;
	localparam logic signed [15:0] RST_DEN   = 16'sh0172;
	localparam logic signed [15:0] RST_FCAP  = 16'sh03e8;
	localparam logic signed [15:0] RST_PREVI = 16'shfed5; // -299 mA
	localparam logic signed [15:0] RST_PREVP = 16'shfb95; // -1131

	// ==========================================================
	// Measurement sample from the converters
	typedef struct packed {
		logic                vld;  // One-cycle sample strobe
		logic signed [15:0]  cur;  // Current, mA, charge positive
		logic        [15:0]  volt; // Cell voltage, mV
		logic signed [15:0]  mean; // Mean current, mA
	} socfl_meas_t;

	// Whole block state
	typedef struct packed {
		logic               hready;
		logic               hresp;
		logic [31:0]        hrdata;
		logic               a_vld;
		logic               a_wr;
		logic [7:0]         a_adr;
		logic               mode;
		logic [2:0]         sel;
		logic signed [15:0] s1set;
		logic signed [15:0] s1clr;
		logic signed [15:0] sfset;
		logic signed [15:0] sfclr;
		logic signed [15:0] dcap;
		logic signed [15:0] den;
		logic signed [15:0] hrate;
		logic signed [15:0] urate;
		logic signed [15:0] rc;
		logic signed [15:0] fcap;
		logic signed [17:0] acc;
		logic               f_init;
		logic               f_final;
		logic               in_dsg;
		logic signed [31:0] sum_i;
		logic signed [31:0] sum_p;
		logic [15:0]        cnt;
		logic signed [15:0] pres_i;
		logic signed [15:0] pres_p;
		logic signed [15:0] prev_i;
		logic signed [15:0] prev_p;
		logic signed [15:0] filt;
		logic signed [15:0] mean;
		logic [15:0]        volt;
		logic signed [15:0] rate;
		logic [NEV-1:0]     istat;
		logic [NEV-1:0]     ien;
		logic               irq;
	} socfl_state_t;

	localparam socfl_state_t ST_RST = '{hready: 1'b1, mode: RST_MODE, sel: RST_SEL,
		s1set: RST_S1SET, s1clr: RST_S1CLR, sfset: RST_SFSET, sfclr: RST_SFCLR,
		dcap: RST_DCAP, den: RST_DEN, fcap: RST_FCAP, prev_i: RST_PREVI,
		prev_p: RST_PREVP, default: '0};

endpackage

// *** verilog/socfl_gauge.sv ***
// Purpose: charge warning flags, coulomb count and load model selection
// Assumes: meas_in.vld pulses once per second; single AHB-Lite master
// Notes:   zero wait state slave, all outputs registered
`timescale 1ns/1ps
module socfl_gauge import socfl_pkg::*; (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Measurements
	input  wire socfl_meas_t meas_in,
	// Status
	output logic             initial_low_charge_flag_out,
	output logic             final_low_charge_flag_out,
	output logic             load_model_status_bit_out,
	output logic signed [15:0] remaining_capacity_value_out,
	output logic signed [15:0] load_rate_out,
	output logic             irq_out
);

	// ==========================================================
	// State and combinational helpers
	socfl_state_t       s;       // Registered state
	socfl_state_t       n;       // Next state
	logic [NEV-1:0]     ev;      // Events this cycle
	logic [NEV-1:0]     clr;     // Software clear mask
	logic signed [17:0] acc_w;   // Charge accumulator, mAs
	logic signed [17:0] q;       // Whole mAh moved
	logic signed [17:0] rc_w;    // Unclamped capacity
	logic signed [32:0] pw;      // Instant power, uW
	logic signed [15:0] p_cw;    // Instant power, 10 mW
	logic signed [32:0] pm;      // Mean power, uW
	logic signed [32:0] pf;      // Filtered power, uW
	logic signed [16:0] df;      // Filter error

	// ==========================================================
	// Next-state logic
	always_comb begin
		n     = s;
		ev    = '0;
		clr   = '0;
		acc_w = '0;
		q     = '0;
		rc_w  = '0;
		pw    = '0;
		p_cw  = '0;
		df    = '0;
		// Data phase of a write; hsize ignored, whole words only
		if (s.a_vld && s.a_wr) begin
			unique case (s.a_adr)
				A_CTRL: begin
					n.mode = hwdata_in[CTRL_MODE_BIT]; // RQ8
					n.sel  = hwdata_in[CTRL_SEL_LSB+:3]; // RQ10 RQ11
				end
				A_S1SET: n.s1set = hwdata_in[15:0];
				A_S1CLR: n.s1clr = hwdata_in[15:0];
				A_SFSET: n.sfset = hwdata_in[15:0];
				A_SFCLR: n.sfclr = hwdata_in[15:0];
				A_DCAP:  n.dcap  = hwdata_in[15:0];
				A_DEN:   n.den   = hwdata_in[15:0];
				A_HRATE: n.hrate = hwdata_in[15:0];
				A_URATE: n.urate = hwdata_in[15:0];
				A_RC:    n.rc    = hwdata_in[15:0];
				A_FCAP:  n.fcap  = hwdata_in[15:0];
				A_IEN:   n.ien   = hwdata_in[NEV-1:0];
				A_ICLR:  clr     = hwdata_in[NEV-1:0];
				default: ; // Read-only or unmapped, ignored
			endcase
		end
		// Measurement sample: count charge, average, filter
		if (meas_in.vld) begin
			n.volt = meas_in.volt;
			n.mean = meas_in.mean;
			acc_w  = s.acc + 18'(meas_in.cur); // RQ1
			q      = acc_w / MAS_PER_MAH; // RQ1
			n.acc  = acc_w - 18'(q * MAS_PER_MAH); // RQ1
			rc_w   = 18'(n.rc) + q; // RQ1
			// Never below empty, never above full
			if (rc_w < 18'sh0)
				n.rc = '0;
			else if (rc_w > 18'(n.fcap))
				n.rc = n.fcap; // RQ2
			else
				n.rc = rc_w[15:0];
			// Flags follow every sampled capacity update; a write of rc alone waits for the next sample
			if (n.rc < n.s1set)
				n.f_init = 1'b1; // RQ3 RQ18
			else if (n.rc > n.s1clr)
				n.f_init = 1'b0; // RQ4
			if (n.sfset != SF_OFF && n.rc < n.sfset)
				n.f_final = 1'b1; // RQ5 RQ6 RQ18
			else if (s.f_final && n.rc > n.sfclr)
				n.f_final = 1'b0; // RQ7
			// Power in 10 mW; wide loads wrap by truncation
			pw   = 33'(meas_in.cur) * $signed({17'h0, meas_in.volt});
			p_cw = 16'(pw / UW_PER_CW);
			if (meas_in.cur < 16'sh0) begin
				// Inside a discharge cycle; the count saturates
				n.in_dsg = 1'b1;
				n.sum_i  = s.sum_i + 32'(meas_in.cur);
				n.sum_p  = s.sum_p + 32'(p_cw);
				if (s.cnt != 16'hffff)
					n.cnt = s.cnt + 16'h1;
				n.pres_i = 16'(n.sum_i / $signed({16'h0, n.cnt}));
				n.pres_p = 16'(n.sum_p / $signed({16'h0, n.cnt}));
			end else if (s.in_dsg) begin
				// Cycle over: keep its average for option zero
				n.prev_i = s.pres_i; // RQ12
				n.prev_p = s.pres_p; // RQ12
				n.in_dsg = 1'b0;
				n.sum_i  = '0;
				n.sum_p  = '0;
				n.cnt    = '0;
				ev[EV_CYC] = 1'b1;
			end
			// First-order low pass, one step per second
			df     = 17'(meas_in.mean) - 17'(s.filt);
			n.filt = s.filt + 16'(df / TAU_S); // RQ13
		end
		ev[EV_S1SET] = n.f_init & ~s.f_init;
		ev[EV_S1CLR] = ~n.f_init & s.f_init;
		ev[EV_SFSET] = n.f_final & ~s.f_final;
		ev[EV_SFCLR] = ~n.f_final & s.f_final;
		// Set wins over a clear in the same cycle
		n.istat = (s.istat & ~clr) | ev;
		n.irq   = |(n.istat & n.ien);
		// Load rate picked from settled sources
		unique case (s.sel)
			3'h0: n.rate = s.mode ? s.prev_p : s.prev_i; // RQ10 RQ11 RQ12
			3'h1: n.rate = s.mode ? s.pres_p : s.pres_i; // RQ10 RQ11
			3'h2: n.rate = s.mode ? 16'(pm / UW_PER_CW) : s.mean; // RQ16
			3'h3: n.rate = s.mode ? 16'(pf / UW_PER_CW) : s.filt; // RQ13
			3'h4: n.rate = s.mode ? s.den / C_DIV : s.dcap / C_DIV; // RQ14 RQ15
			3'h5: n.rate = s.hrate; // RQ17
			3'h6: n.rate = s.urate;
			default: n.rate = '0; // Code seven unused
		endcase
		// Address phase; read data taken after this cycle's write
		n.a_vld = hsel_in && htrans_in[1] && hready_in;
		n.a_wr  = hwrite_in;
		n.a_adr = haddr_in[7:0];
		if (n.a_vld && !hwrite_in) begin
			unique case (haddr_in[7:0])
				A_CTRL:  n.hrdata = 32'({n.sel, 3'h0, n.mode});
				A_FLAGS: n.hrdata = 32'({n.f_init, n.f_final, 1'b0});
				A_S1SET: n.hrdata = 32'(n.s1set);
				A_S1CLR: n.hrdata = 32'(n.s1clr);
				A_SFSET: n.hrdata = 32'(n.sfset);
				A_SFCLR: n.hrdata = 32'(n.sfclr);
				A_DCAP:  n.hrdata = 32'(n.dcap);
				A_DEN:   n.hrdata = 32'(n.den);
				A_HRATE: n.hrdata = 32'(n.hrate);
				A_URATE: n.hrdata = 32'(n.urate);
				A_RC:    n.hrdata = 32'(n.rc);
				A_FCAP:  n.hrdata = 32'(n.fcap);
				A_RATE:  n.hrdata = 32'(s.rate);
				A_ISTAT: n.hrdata = 32'(n.istat);
				A_IEN:   n.hrdata = 32'(n.ien);
				A_CSTAT: n.hrdata = 32'(n.mode); // RQ9
				default: n.hrdata = '0; // Unmapped or write-only
			endcase
		end
	end

	// Mean and filtered power from held voltage
	assign pm = 33'(s.mean) * $signed({17'h0, s.volt}); // RQ16
	assign pf = 33'(s.filt) * $signed({17'h0, s.volt});

	// ==========================================================
	// State register
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			s <= ST_RST;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// Outputs, all straight from state
	assign hrdata_out                   = s.hrdata;
	assign hreadyout_out                = s.hready;
	assign hresp_out                    = s.hresp;
	assign initial_low_charge_flag_out  = s.f_init;
	assign final_low_charge_flag_out    = s.f_final;
	assign load_model_status_bit_out    = s.mode; // RQ9
	assign remaining_capacity_value_out = s.rc;
	assign load_rate_out                = s.rate;
	assign irq_out                      = s.irq;

	// ==========================================================
	// Assertions
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);

	s1_set_a: assert property ($rose(s.f_init) |-> s.rc < s.s1set) else $error("initial flag raised early"); // RQ3
	s1_clr_a: assert property ($fell(s.f_init) |-> s.rc > s.s1clr) else $error("initial flag cleared early"); // RQ4
	sf_set_a: assert property ($rose(s.f_final) |-> s.rc < s.sfset) else $error("final flag raised early"); // RQ5
	sf_off_a: assert property ($rose(s.f_final) |-> s.sfset != SF_OFF) else $error("final flag while off"); // RQ6
	sf_clr_a: assert property ($fell(s.f_final) |-> s.rc > s.sfclr) else $error("final flag cleared early"); // RQ7
	load_model_status_bit_mirror_a: assert property (s.a_vld && s.a_wr && s.a_adr == A_CTRL
		|=> load_model_status_bit_out == $past(hwdata_in[CTRL_MODE_BIT])) else $error("mode bit not mirrored"); // RQ9
	cc_c5_a: assert property (!s.mode && s.sel == 3'h4 |=> s.rate == $past(s.dcap) / C_DIV)
		else $error("current C/5 rate wrong"); // RQ14
	cp_c5_a: assert property (s.mode && s.sel == 3'h4 |=> s.rate == $past(s.den) / C_DIV)
		else $error("power C/5 rate wrong"); // RQ15
	rc_cap_a: assert property (meas_in.vld |=> s.rc <= s.fcap && s.rc >= 16'sh0)
		else $error("capacity out of range"); // RQ2
	upd_flag_a: assert property (meas_in.vld && s.a_vld == 1'b0 ##1 s.rc < s.s1set |-> s.f_init)
		else $error("initial flag missed"); // RQ18

	init_c: cover property ($rose(s.f_init));
	final_c: cover property ($rose(s.f_final) ##[1:1000] $fell(s.f_final));
	cyc_c: cover property (s.in_dsg ##1 !s.in_dsg);
	irq_c: cover property ($rose(irq_out));

endmodule

// *** tb/socfl_host.sv ***
// Purpose: host processor model, AHB-Lite master for single word transfers
// Assumes: one slave, its hreadyout fed back as hready
// Notes:   address and data lines go to inverted values once released
`timescale 1ns/1ps
module socfl_host (
	// Clock
	input  wire logic        clock_in,
	// Slave answer
	input  wire logic        hready_in,
	input  wire logic [31:0] hrdata_in,
	// Master request
	output logic             hsel_out,
	output logic [31:0]      haddr_out,
	output logic [1:0]       htrans_out,
	output logic             hwrite_out,
	output logic [2:0]       hsize_out,
	output logic [31:0]      hwdata_out
);
	int timeouts = 0; // Waits that ran out
	initial begin
		hsel_out   = 1'b1;
		haddr_out  = 32'h0;
		htrans_out = 2'h0;
		hwrite_out = 1'b0;
		hsize_out  = 3'h2;
		hwdata_out = 32'h0;
	end
	// ==========================================================
	// One transfer; no cycle count assumed, only a bounded wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clock_in);
		haddr_out  <= {24'h0, a};
		htrans_out <= 2'h2;
		hwrite_out <= w;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (hready_in !== 1'b1 && n < 50);
		// Address phase never accepted counts as a timeout too
		if (hready_in !== 1'b1)
			timeouts++;
		htrans_out <= 2'h0;
		haddr_out  <= ~{24'h0, a}; // Released address shows nothing stale
		hwdata_out <= d;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (hready_in !== 1'b1 && n < 50);
		r = hrdata_in;
		hwdata_out <= ~d; // Released data shows nothing stale
		if (hready_in !== 1'b1)
			timeouts++;
	endtask
endmodule

// *** tb/socfl_gauge_tb.sv ***
// Purpose: self-checking bench of the charge warning and load model block
// Assumes: zero wait state slave, one sample per second
// Notes:   flag and rate expectations come from bench models
`timescale 1ns/1ps
module socfl_gauge_tb import socfl_pkg::*;;
	logic clk = 1'b0, rst = 1'b1;
	logic hsel, hwrite, hrdy, hresp, f_i, f_f, load_model_status_bit, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic signed [15:0] rc, rate;
	socfl_meas_t meas = '0;
	int miscompares = 0, compares = 0;
	int erc = 0, sfs = 75, m, v, hr, ur, k;
	logic ei = 1'b0, ef = 1'b0;
	// Rate source models: filter, present and previous averages
	int ft = 0, si = 0, sp = 0, cn = 0, pi = 0, pp = 0, pvi = -299, pvp = -1131;
	logic dsg = 1'b0;
	int seq[6] = '{175, 176, 74, 100, 101, 160};
	socfl_host u_host (.clock_in(clk), .hready_in(hrdy), .hrdata_in(hrdata), .hsel_out(hsel),
		.haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
	socfl_gauge u_dut (.clock_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
		.hreadyout_out(hrdy), .hresp_out(hresp), .meas_in(meas), .initial_low_charge_flag_out(f_i),
		.final_low_charge_flag_out(f_f), .load_model_status_bit_out(load_model_status_bit),
		.remaining_capacity_value_out(rc), .load_rate_out(rate), .irq_out(irq));
	initial forever #2.5 clk = ~clk;
	// ==========================================================
	// Compare tasks
	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		chk_w({31'h0, g}, {31'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rd);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		u_host.xfer(1'b0, a, 32'h0, rd);
		chk_w(rd, e);
		chk_b(hresp, 1'b0);
	endtask
	// ==========================================================
	// Sample with flag model; hysteresis, final set disabled at -1
	task automatic smp(input int c);
		@(posedge clk);
		meas <= '{vld: 1'b1, cur: 16'(c), volt: 16'(v), mean: 16'(m)};
		@(posedge clk);
		meas.vld <= 1'b0;
		// Outputs launched at the sampling edge are read one edge later
		@(posedge clk);
		erc = erc + c / 3600;
		ft = ft + (m - ft) / 14;
		if (c < 0) begin
			dsg = 1'b1;
			si = si + c;
			sp = sp + (c * v) / 10000;
			cn++;
			pi = si / cn;
			pp = sp / cn;
		end else if (dsg) begin
			pvi = pi;
			pvp = pp;
			dsg = 1'b0;
			si = 0;
			sp = 0;
			cn = 0;
		end
		if (erc < 150) ei = 1'b1;
		else if (erc > 175) ei = 1'b0;
		if (sfs != -1 && erc < sfs) ef = 1'b1;
		else if (ef && erc > 100) ef = 1'b0;
		chk_w(32'(rc), 32'(erc));
		chk_b(f_i, ei);
		chk_b(f_f, ef);
		repeat (2) @(posedge clk);
	endtask
	// Expected rate of a model and selector
	function automatic int exp_rate(input int md, input int s);
		case (s)
			0: return md ? pvp : pvi;
			1: return md ? pp : pi;
			3: return md ? (ft * v) / 10000 : ft;
			2: return md ? (m * v) / 10000 : m;
			4: return md ? 370 / 5 : 1000 / 5;
			5: return hr;
			6: return ur;
			default: return 0;
		endcase
	endfunction
	task automatic results();
		miscompares += u_host.timeouts;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'hd2f77d12));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdc(A_CTRL, 32'h10);
		rdc(8'h80, 32'h0);
		v = 3000 + $urandom_range(1200);
		m = -$urandom_range(1000);
		hr = $urandom_range(32767);
		ur = -$urandom_range(32767);
		wr(A_HRATE, 32'(hr));
		wr(A_URATE, 32'(ur));
		for (int md = 0; md < 2; md++) begin
			for (int s = 0; s < 8; s++) begin
				wr(A_CTRL, 32'((s << 4) | md));
				smp(0);
				chk_w(32'(rate), 32'(exp_rate(md, s)));
				chk_b(load_model_status_bit, md[0]);
			end
			rdc(A_CSTAT, 32'(md));
		end
		wr(A_FLAGS, 32'h0);
		rdc(A_FLAGS, {29'h0, ei, ef, 1'b0});
		erc = 200;
		wr(A_RC, 32'(erc));
		smp(0);
		wr(A_ICLR, 32'h1f);
		wr(A_IEN, 32'h0);
		erc = 149;
		wr(A_RC, 32'(erc));
		smp(0);
		rdc(A_ISTAT, 32'h1);
		chk_b(irq, 1'b0);
		wr(A_IEN, 32'h1);
		repeat (2) @(posedge clk);
		chk_b(irq, 1'b1);
		wr(A_ICLR, 32'h1);
		repeat (2) @(posedge clk);
		chk_b(irq, 1'b0);
		foreach (seq[i]) begin
			erc = seq[i];
			wr(A_RC, 32'(erc));
			smp(0);
		end
		sfs = -1;
		wr(A_SFSET, 32'hffffffff);
		erc = 10;
		wr(A_RC, 32'(erc));
		smp(0);
		erc = 500;
		wr(A_RC, 32'(erc));
		for (int i = 0; i < 6; i++) begin
			k = $urandom_range(2);
			smp(-3600 * k);
		end
		// Sure discharge, then end the cycle and check averages
		smp(-3600);
		wr(A_ICLR, 32'h1f);
		wr(A_CTRL, 32'h10);
		smp(0);
		chk_w(32'(rate), 32'(exp_rate(0, 1)));
		rdc(A_ISTAT, 32'h10);
		wr(A_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk_w(32'(rate), 32'(exp_rate(0, 0)));
		results();
	end
	initial begin
		#400000;
		miscompares++;
		results();
	end
endmodule
